// ==== src/tx_serial_signal_output_pin_source_select.sv ====
/*
 * Source selection for the antenna drivers, the serial signal output
 * pin and the contactless UART input, plus the post-transmit receiver
 * guard. Assumes all tap inputs are synchronous to pclk except the
 * signal input pin, which is synchronised here. Bit clock is an
 * enable pulse from the bit-rate divider.
 */
// Notes on behaviour
// - Driver field picks antenna driver source
// - Soft power-down tristates only on tristate code
// - Constant high follows driver inversion settings
// - Output codes 0..2: tristate, low, high
// - Code 3 routes selected test bus bit
// - Codes 4,5: coder envelope, transmit stream
// - Code 6 regenerated receiver signal
// - Code 7 decoded received stream
// - Codes 8..11 secure module taps, 11 reserved
// - Codes 12..15 type-A secure module taps
// - Receiver select register layout, reset 84h
// - UART input select codes
// - Receiver wait in bit clocks after transmit
// - Inversion bit per driver state
`timescale 1ns/10ps
module tx_serial_signal_output_pin_source_select
	import txsel_pkg::*;
#(
	parameter int TEST_BUS_WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic soft_power_down,
	input wire logic driver1_enabled,
	input wire logic driver2_enabled,
	input wire logic coder_envelope,
	input wire logic tx_serial_data,
	input wire logic rx_regenerated,
	input wire logic rx_serial_data,
	input wire logic analog_modulation,
	input wire logic [TEST_BUS_WIDTH-1:0] test_bus,
	input wire logic sam_f_rx,
	input wire logic sam_f_tx,
	input wire logic sam_f_comparator,
	input wire logic sam_a_rx_carrier,
	input wire logic sam_a_tx_carrier,
	input wire logic sam_a_rx_unfiltered,
	input wire logic sam_a_rx_envelope,
	input wire logic signal_input_pin,
	input wire logic bit_clock_en,
	input wire logic transmit_done,
	input wire logic receive_only_cmd,
	output logic antenna_output_one,
	output logic antenna_output_one_oe_n,
	output logic antenna_output_two,
	output logic antenna_output_two_oe_n,
	output logic serial_signal_output_pin,
	output logic serial_signal_output_pin_oe_n,
	output logic uart_input,
	output logic receiver_active
);
	// ==========================================================
	// Register state
	logic [7:0] tx_source_select_q, tx_source_select_d;
	logic [7:0] receiver_select_q, receiver_select_d;
	logic [7:0] tx_control_q, tx_control_d;
	logic [7:0] test_select_q, test_select_d;
	logic [31:0] prdata_q, prdata_d;
	logic pslverr_q, pslverr_d;
	logic [1:0] signal_input_pin_sync_q;
	logic signal_input_pin_s;

	function automatic logic addr_known(input logic [31:0] a);
		addr_known = (a[9:0] == TX_SOURCE_SELECT_ADDR) || (a[9:0] == RECEIVER_SELECT_ADDR) ||
			(a[9:0] == TX_CONTROL_ADDR) || (a[9:0] == TEST_SELECT_ADDR) ||
			(a[9:0] == STATUS_ADDR);
		addr_known = addr_known && (a[31:10] == 22'h0);
	endfunction : addr_known

	// Inversion bit that applies to the driver's present state
	function automatic logic inv_select(input logic enabled, input logic on_bit,
		input logic off_bit);
		inv_select = enabled ? on_bit : off_bit;
	endfunction : inv_select

	logic setup;
	logic wr_en;
	assign setup = psel && !penable;
	// Writes land only at the completing access edge
	assign wr_en = psel && penable && pready && pwrite && pstrb[0] && addr_known(paddr);
	// No wait states: every access completes in one cycle
	assign pready = 1'b1;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;

	logic [5:0] wait_cnt_q, wait_cnt_d;
	logic rx_act_q, rx_act_d;

	// ==========================================================
	// Register next state (read data latched in setup, write in access)
	always_comb begin
		tx_source_select_d = tx_source_select_q;
		receiver_select_d = receiver_select_q;
		tx_control_d = tx_control_q;
		test_select_d = test_select_q;
		prdata_d = prdata_q;
		pslverr_d = pslverr_q;
		if (setup) begin
			pslverr_d = !addr_known(paddr);
			prdata_d = 32'h0;
			if (!pwrite) begin
				case (paddr[9:0])
					TX_SOURCE_SELECT_ADDR: prdata_d = {24'h0, tx_source_select_q};
					RECEIVER_SELECT_ADDR: prdata_d = {24'h0, receiver_select_q};
					TX_CONTROL_ADDR: prdata_d = {24'h0, tx_control_q};
					TEST_SELECT_ADDR: prdata_d = {24'h0, test_select_q};
					STATUS_ADDR: prdata_d = {26'h0, rx_act_q, wait_cnt_q[4:0]};
					default: prdata_d = 32'h0;
				endcase
				if (!addr_known(paddr)) begin
					prdata_d = 32'h0;
				end
			end
		end
		if (wr_en) begin
			case (paddr[9:0])
				TX_SOURCE_SELECT_ADDR: tx_source_select_d = pwdata[7:0] & TX_SOURCE_SELECT_MASK;
				RECEIVER_SELECT_ADDR: receiver_select_d = pwdata[7:0];
				TX_CONTROL_ADDR: tx_control_d = pwdata[7:0];
				TEST_SELECT_ADDR: test_select_d = pwdata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_source_select_q <= TX_SOURCE_SELECT_RST;
			receiver_select_q <= RECEIVER_SELECT_RST;
			tx_control_q <= TX_CONTROL_RST;
			test_select_q <= TEST_SELECT_RST;
			prdata_q <= 32'h0;
			pslverr_q <= 1'b0;
		end else begin
			tx_source_select_q <= tx_source_select_d;
			receiver_select_q <= receiver_select_d;
			tx_control_q <= tx_control_d;
			test_select_q <= test_select_d;
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	// ==========================================================
	// Signal input pin synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			signal_input_pin_sync_q <= 2'b00;
		end else begin
			signal_input_pin_sync_q <= {signal_input_pin_sync_q[0], signal_input_pin};
		end
	end
	// Only the second stage feeds logic
	assign signal_input_pin_s = signal_input_pin_sync_q[1];

	// ==========================================================
	// Receiver guard counter
	always_comb begin
		wait_cnt_d = wait_cnt_q;
		rx_act_d = rx_act_q;
		if (receive_only_cmd) begin
			wait_cnt_d = 6'h0;
			rx_act_d = 1'b1;
		end else if (transmit_done) begin
			wait_cnt_d = receiver_select_q[WAIT_LSB +: 6];
			rx_act_d = (receiver_select_q[WAIT_LSB +: 6] == 6'h0);
		end else if (!rx_act_q && bit_clock_en) begin
			wait_cnt_d = wait_cnt_q - 6'h1;
			rx_act_d = (wait_cnt_q == 6'h1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_cnt_q <= 6'h0;
			rx_act_q <= 1'b1;
		end else begin
			wait_cnt_q <= wait_cnt_d;
			rx_act_q <= rx_act_d;
		end
	end

	// ==========================================================
	// Output selection (registered)
	logic [1:0] drv_sel;
	logic [3:0] out_sel;
	logic drv_src, inv1, inv2, sig_src, sig_oe_n, uart_src;
	logic ant1_q, ant2_q, ant1_oen_q, ant2_oen_q, sig_q, sig_oen_q, uart_q;
	logic ant1_d, ant2_d, ant1_oen_d, ant2_oen_d, sig_d, sig_oen_d, uart_d;
	assign drv_sel = tx_source_select_q[DRV_LSB +: 2];
	assign out_sel = tx_source_select_q[OUT_LSB +: 4];

	always_comb begin
		case (drv_sel)
			DRV_CODER: drv_src = coder_envelope;
			DRV_SIGNAL_INPUT_PIN: drv_src = signal_input_pin_s;
			DRV_HIGH: drv_src = 1'b1;
			default: drv_src = 1'b0;
		endcase
		inv1 = inv_select(driver1_enabled, tx_control_q[INV1_ON_BIT], tx_control_q[INV1_OFF_BIT]);
		inv2 = inv_select(driver2_enabled, tx_control_q[INV2_ON_BIT], tx_control_q[INV2_OFF_BIT]);
		sig_oe_n = 1'b0;
		case (out_sel)
			OUT_TRISTATE: begin
				sig_src = 1'b0;
				sig_oe_n = 1'b1;
			end
			OUT_LOW: sig_src = 1'b0;
			OUT_HIGH: sig_src = 1'b1;
			OUT_TESTBUS: sig_src = test_bus[test_select_q[TESTBIT_LSB +: 3] %
				TEST_BUS_WIDTH];
			OUT_CODER: sig_src = coder_envelope;
			OUT_TXDATA: sig_src = tx_serial_data;
			OUT_REGEN: sig_src = rx_regenerated;
			OUT_RXDATA: sig_src = rx_serial_data;
			OUT_F_RX: sig_src = sam_f_rx;
			OUT_F_TX: sig_src = sam_f_tx;
			OUT_F_COMP: sig_src = sam_f_comparator;
			OUT_F_RSVD: sig_src = 1'b0;
			OUT_A_RXC: sig_src = sam_a_rx_carrier;
			OUT_A_TXC: sig_src = sam_a_tx_carrier;
			OUT_A_RXU: sig_src = sam_a_rx_unfiltered;
			OUT_A_ENV: sig_src = sam_a_rx_envelope;
			default: sig_src = 1'b0;
		endcase
		case (receiver_select_q[UART_LSB +: 2])
			UART_SIGNAL_INPUT_PIN_ENV: uart_src = signal_input_pin_s;
			UART_ANALOG: uart_src = analog_modulation;
			UART_SIGNAL_INPUT_PIN_MOD: uart_src = signal_input_pin_s;
			default: uart_src = 1'b0;
		endcase
		uart_src = uart_src && rx_act_q;
		ant1_d = drv_src ^ inv1;
		ant2_d = drv_src ^ inv2;
		ant1_oen_d = (drv_sel == DRV_TRISTATE);
		ant2_oen_d = (drv_sel == DRV_TRISTATE);
		sig_d = sig_src;
		sig_oen_d = sig_oe_n;
		uart_d = uart_src;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ant1_q <= 1'b0;
			ant2_q <= 1'b0;
			ant1_oen_q <= 1'b1;
			ant2_oen_q <= 1'b1;
			sig_q <= 1'b0;
			sig_oen_q <= 1'b1;
			uart_q <= 1'b0;
		end else begin
			ant1_q <= ant1_d;
			ant2_q <= ant2_d;
			ant1_oen_q <= ant1_oen_d;
			ant2_oen_q <= ant2_oen_d;
			sig_q <= sig_d;
			sig_oen_q <= sig_oen_d;
			uart_q <= uart_d;
		end
	end

	assign antenna_output_one = ant1_q;
	assign antenna_output_two = ant2_q;
	assign antenna_output_one_oe_n = ant1_oen_q;
	assign antenna_output_two_oe_n = ant2_oen_q;
	assign serial_signal_output_pin = sig_q;
	assign serial_signal_output_pin_oe_n = sig_oen_q;
	assign uart_input = uart_q;
	assign receiver_active = rx_act_q;

	logic unused;
	assign unused = soft_power_down ^ (^pwdata[31:8]) ^ (^pstrb[3:1]) ^ (^test_select_q[7:3]);
endmodule : tx_serial_signal_output_pin_source_select

// ==== src/txsel_pkg.sv ====
/*
 * Package for the transmit/receive source selection block: register
 * indices, field positions, reset values and selection codes.
 * Assumes an APB slave with 32-bit data, one register per aligned word.
 */
package txsel_pkg;
	// ==========================================================
	// Register map (printed offsets are indices; byte addr = 4*index)
	localparam logic [7:0] TX_SOURCE_SELECT_IDX = 8'h16;
	localparam logic [7:0] RECEIVER_SELECT_IDX = 8'h17;
	localparam logic [7:0] TX_CONTROL_IDX = 8'h14;
	localparam logic [7:0] TEST_SELECT_IDX = 8'h31;
	localparam logic [7:0] STATUS_IDX = 8'h3f;
	localparam logic [9:0] TX_SOURCE_SELECT_ADDR = {TX_SOURCE_SELECT_IDX, 2'b00};
	localparam logic [9:0] RECEIVER_SELECT_ADDR = {RECEIVER_SELECT_IDX, 2'b00};
	localparam logic [9:0] TX_CONTROL_ADDR = {TX_CONTROL_IDX, 2'b00};
	localparam logic [9:0] TEST_SELECT_ADDR = {TEST_SELECT_IDX, 2'b00};
	localparam logic [9:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
	// ==========================================================
	// Reset values
	localparam logic [7:0] TX_SOURCE_SELECT_RST = 8'h10;
	localparam logic [7:0] RECEIVER_SELECT_RST = 8'h84;
	localparam logic [7:0] TX_CONTROL_RST = 8'h80;
	localparam logic [7:0] TEST_SELECT_RST = 8'h00;
	// ==========================================================
	// Field positions
	localparam int DRV_LSB = 4;
	localparam int OUT_LSB = 0;
	localparam int UART_LSB = 6;
	localparam int WAIT_LSB = 0;
	localparam logic [7:0] TX_SOURCE_SELECT_MASK = 8'h3f;
	localparam int INV2_ON_BIT = 7;
	localparam int INV1_ON_BIT = 6;
	localparam int INV2_OFF_BIT = 5;
	localparam int INV1_OFF_BIT = 4;
	localparam int TESTBIT_LSB = 0;
	// ==========================================================
	// Driver source codes
	localparam logic [1:0] DRV_TRISTATE = 2'h0;
	localparam logic [1:0] DRV_CODER = 2'h1;
	localparam logic [1:0] DRV_SIGNAL_INPUT_PIN = 2'h2;
	localparam logic [1:0] DRV_HIGH = 2'h3;
	// ==========================================================
	// Output pin source codes
	localparam logic [3:0] OUT_TRISTATE = 4'h0;
	localparam logic [3:0] OUT_LOW = 4'h1;
	localparam logic [3:0] OUT_HIGH = 4'h2;
	localparam logic [3:0] OUT_TESTBUS = 4'h3;
	localparam logic [3:0] OUT_CODER = 4'h4;
	localparam logic [3:0] OUT_TXDATA = 4'h5;
	localparam logic [3:0] OUT_REGEN = 4'h6;
	localparam logic [3:0] OUT_RXDATA = 4'h7;
	localparam logic [3:0] OUT_F_RX = 4'h8;
	localparam logic [3:0] OUT_F_TX = 4'h9;
	localparam logic [3:0] OUT_F_COMP = 4'ha;
	localparam logic [3:0] OUT_F_RSVD = 4'hb;
	localparam logic [3:0] OUT_A_RXC = 4'hc;
	localparam logic [3:0] OUT_A_TXC = 4'hd;
	localparam logic [3:0] OUT_A_RXU = 4'he;
	localparam logic [3:0] OUT_A_ENV = 4'hf;
	// ==========================================================
	// UART input select codes
	localparam logic [1:0] UART_LOW = 2'h0;
	localparam logic [1:0] UART_SIGNAL_INPUT_PIN_ENV = 2'h1;
	localparam logic [1:0] UART_ANALOG = 2'h2;
	localparam logic [1:0] UART_SIGNAL_INPUT_PIN_MOD = 2'h3;
endpackage : txsel_pkg

// ==== sim/tx_serial_signal_output_pin_far_side_model.sv ====
/* Far-side model: secure module taps, test bus and signal input pin.
   Assumes pclk and presetn from the bench; outputs move after pclk rises. */
`timescale 1ns/10ps
module tx_serial_signal_output_pin_far_side_model (
	input wire logic pclk,
	input wire logic presetn,
	output logic [15:0] taps,
	output logic signal_input_pin
);
	// ==========================================================
	// Pattern state
	logic [15:0] lfsr_q;
	logic [15:0] lfsr_d;
	logic [3:0] div_q;
	logic [3:0] div_d;
	always_comb begin
		lfsr_d = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
		div_d = div_q + 4'h1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lfsr_q <= 16'hace1;
			div_q <= 4'h0;
		end else begin
			lfsr_q <= lfsr_d;
			div_q <= div_d;
		end
	end
	assign taps = lfsr_q;
	// Slow pin so the synchroniser delay can settle between edges
	assign signal_input_pin = div_q[3];
endmodule : tx_serial_signal_output_pin_far_side_model

// ==== sim/tx_serial_signal_output_pin_source_select_asserts.sv ====
/* Port checker for tx_serial_signal_output_pin_source_select, bound to the design.
   Assumes APB writes commit at the access edge when pstrb[0] is set. */
`timescale 1ns/10ps
module tx_serial_signal_output_pin_source_select_asserts
	import txsel_pkg::*;
#(
	parameter int TEST_BUS_WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic driver1_enabled,
	input wire logic coder_envelope,
	input wire logic tx_serial_data,
	input wire logic rx_regenerated,
	input wire logic rx_serial_data,
	input wire logic [TEST_BUS_WIDTH-1:0] test_bus,
	input wire logic sam_f_rx,
	input wire logic sam_f_tx,
	input wire logic sam_f_comparator,
	input wire logic sam_a_rx_carrier,
	input wire logic sam_a_tx_carrier,
	input wire logic sam_a_rx_unfiltered,
	input wire logic sam_a_rx_envelope,
	input wire logic transmit_done,
	input wire logic receive_only_cmd,
	input wire logic antenna_output_one,
	input wire logic antenna_output_one_oe_n,
	input wire logic antenna_output_two_oe_n,
	input wire logic serial_signal_output_pin,
	input wire logic serial_signal_output_pin_oe_n,
	input wire logic uart_input,
	input wire logic receiver_active
);
	// ==========================================================
	// Register mirror
	logic [7:0] tss_q;
	logic [7:0] rxs_q;
	logic [7:0] ctl_q;
	logic [7:0] tst_q;
	logic sig_exp;
	logic inv1;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tss_q <= TX_SOURCE_SELECT_RST;
			rxs_q <= RECEIVER_SELECT_RST;
			ctl_q <= TX_CONTROL_RST;
			tst_q <= TEST_SELECT_RST;
		end else if (psel && penable && pwrite && pstrb[0] && paddr[31:10] == 22'h0) begin
			case (paddr[9:0])
				TX_SOURCE_SELECT_ADDR: tss_q <= pwdata[7:0] & TX_SOURCE_SELECT_MASK;
				RECEIVER_SELECT_ADDR: rxs_q <= pwdata[7:0];
				TX_CONTROL_ADDR: ctl_q <= pwdata[7:0];
				TEST_SELECT_ADDR: tst_q <= pwdata[7:0];
				default: ;
			endcase
		end
	end
	assign inv1 = driver1_enabled ? ctl_q[INV1_ON_BIT] : ctl_q[INV1_OFF_BIT];
	always_comb begin
		case (tss_q[3:0])
			OUT_HIGH: sig_exp = 1'b1;
			OUT_TESTBUS: sig_exp = test_bus[tst_q[2:0]];
			OUT_CODER: sig_exp = coder_envelope;
			OUT_TXDATA: sig_exp = tx_serial_data;
			OUT_REGEN: sig_exp = rx_regenerated;
			OUT_RXDATA: sig_exp = rx_serial_data;
			OUT_F_RX: sig_exp = sam_f_rx;
			OUT_F_TX: sig_exp = sam_f_tx;
			OUT_F_COMP: sig_exp = sam_f_comparator;
			OUT_A_RXC: sig_exp = sam_a_rx_carrier;
			OUT_A_TXC: sig_exp = sam_a_tx_carrier;
			OUT_A_RXU: sig_exp = sam_a_rx_unfiltered;
			OUT_A_ENV: sig_exp = sam_a_rx_envelope;
			default: sig_exp = 1'b0;
		endcase
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_sig_float: assert property (tss_q[3:0] == OUT_TRISTATE |=> serial_signal_output_pin_oe_n)
		else $error("signal output driven under tristate code");
	chk_sig_source: assert property (tss_q[3:0] != OUT_TRISTATE |=>
		!serial_signal_output_pin_oe_n && serial_signal_output_pin == $past(sig_exp))
		else $error("signal output source wrong");
	chk_drv_float: assert property (tss_q[5:4] == DRV_TRISTATE |=>
		antenna_output_one_oe_n && antenna_output_two_oe_n)
		else $error("antenna driven under tristate code");
	chk_drv_active: assert property (tss_q[5:4] != DRV_TRISTATE |=>
		!antenna_output_one_oe_n && !antenna_output_two_oe_n)
		else $error("antenna released under active code");
	chk_drv_high: assert property (tss_q[5:4] == DRV_HIGH |=> antenna_output_one == !$past(inv1))
		else $error("constant level ignores inversion");
	chk_drv_coder: assert property (tss_q[5:4] == DRV_CODER
		|=> antenna_output_one == $past(coder_envelope ^ inv1))
		else $error("antenna not following coder");
	chk_uart_low: assert property (rxs_q[7:6] == UART_LOW |=> !uart_input)
		else $error("uart input not low");
	chk_guard_start: assert property (transmit_done && !receive_only_cmd && rxs_q[5:0] != 6'h00
		|-> ##[1:2] !receiver_active)
		else $error("receiver guard did not start");
	chk_recv_only: assert property (receive_only_cmd |-> ##[1:2] receiver_active)
		else $error("receive command did not activate");
	cover property (tss_q[3:0] == OUT_TESTBUS);
	cover property (tss_q[5:4] == DRV_HIGH);
	cover property (transmit_done && rxs_q[5:0] != 6'h00);
endmodule : tx_serial_signal_output_pin_source_select_asserts
bind tx_serial_signal_output_pin_source_select tx_serial_signal_output_pin_source_select_asserts #(.TEST_BUS_WIDTH(TEST_BUS_WIDTH)) i_chk (.*);

// ==== sim/tx_serial_signal_output_pin_source_select_tb.sv ====
/* Self-checking bench for tx_serial_signal_output_pin_source_select.
   Assumes the far-side model supplies taps and the signal input pin. */
`timescale 1ns/10ps
module tx_serial_signal_output_pin_source_select_tb;
	import txsel_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic soft_power_down = 1'b0;
	logic driver1_enabled = 1'b1;
	logic bit_clock_en = 1'b0;
	logic transmit_done = 1'b0;
	logic receive_only_cmd = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, antenna_output_one, antenna_output_one_oe_n, antenna_output_two;
	logic antenna_output_two_oe_n, serial_signal_output_pin, serial_signal_output_pin_oe_n;
	logic uart_input, receiver_active, signal_input_pin;
	logic [15:0] taps;
	int mismatches = 0;
	int n_checks = 0;
	always #5 pclk = ~pclk;
	tx_serial_signal_output_pin_far_side_model i_far (.pclk(pclk), .presetn(presetn), .taps(taps),
		.signal_input_pin(signal_input_pin));
	tx_serial_signal_output_pin_source_select i_dut (.*, .driver2_enabled(!driver1_enabled), .coder_envelope(taps[4]),
		.tx_serial_data(taps[5]), .rx_regenerated(taps[6]), .rx_serial_data(taps[7]),
		.analog_modulation(taps[1]), .test_bus(taps[7:0]), .sam_f_rx(taps[8]),
		.sam_f_tx(taps[9]), .sam_f_comparator(taps[10]), .sam_a_rx_carrier(taps[12]),
		.sam_a_tx_carrier(taps[13]), .sam_a_rx_unfiltered(taps[14]),
		.sam_a_rx_envelope(taps[15]));
	// ==========================================================
	// Shared tasks
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_word
	task automatic check_bit(input logic got, input logic exp);
		check_word({31'h0, got}, {31'h0, exp});
	endtask : check_bit
	task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {22'h0, a};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish
	// ==========================================================
	// Scenarios
	task automatic t_regs();
		logic [31:0] d;
		logic e;
		apb(1'b0, TX_SOURCE_SELECT_ADDR, 32'h0, d, e);
		check_word(d, 32'h10);
		apb(1'b0, RECEIVER_SELECT_ADDR, 32'h0, d, e);
		check_word(d, 32'h84);
		apb(1'b1, TX_SOURCE_SELECT_ADDR, 32'hffffffff, d, e);
		apb(1'b0, TX_SOURCE_SELECT_ADDR, 32'h0, d, e);
		check_word(d, 32'h3f);
		apb(1'b0, 10'h000, 32'h0, d, e);
		check_bit(e, 1'b1);
	endtask : t_regs
	task automatic t_serial_signal_output_pin();
		logic [31:0] d;
		logic e;
		logic [15:0] ev;
		apb(1'b1, TEST_SELECT_ADDR, 32'h3, d, e);
		// Receiving state first; codes 6 and 7 used outside type-A mode
		@(posedge pclk);
		receive_only_cmd <= 1'b1;
		@(posedge pclk);
		receive_only_cmd <= 1'b0;
		for (int c = 0; c < 16; c++) begin
			apb(1'b1, TX_SOURCE_SELECT_ADDR, {24'h1, 4'h1, c[3:0]}, d, e);
			repeat (2) @(posedge pclk);
			#1 check_bit(serial_signal_output_pin_oe_n, c == 0);
			repeat (4) begin
				ev = taps;
				ev[1] = 1'b0;
				ev[2] = 1'b1;
				ev[11] = 1'b0;
				@(posedge pclk);
				#1 if (c != 0) check_bit(serial_signal_output_pin, ev[c]);
			end
		end
	endtask : t_serial_signal_output_pin
	task automatic t_drivers();
		logic [31:0] d;
		logic e;
		apb(1'b1, TX_CONTROL_ADDR, 32'h60, d, e);
		soft_power_down <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, TX_SOURCE_SELECT_ADDR, {26'h0, c[1:0], 4'h2}, d, e);
			for (int en = 0; en < 2; en++) begin
				@(posedge pclk);
				driver1_enabled <= en[0];
				@(signal_input_pin);
				repeat (4) @(posedge pclk);
				#1 check_bit(antenna_output_one_oe_n, c == 0);
				check_bit(antenna_output_two_oe_n, c == 0);
				if (c == 3) check_bit(antenna_output_one, !en[0]);
				if (c == 3) check_bit(antenna_output_two, !en[0]);
				if (c == 2) check_bit(antenna_output_one, signal_input_pin ^ en[0]);
				if (c == 2) check_bit(antenna_output_two, signal_input_pin ^ en[0]);
			end
		end
		@(posedge pclk);
		soft_power_down <= 1'b0;
	endtask : t_drivers
	task automatic t_guard();
		logic [31:0] d;
		logic e;
		logic ev;
		apb(1'b1, RECEIVER_SELECT_ADDR, {24'h0, UART_ANALOG, 6'd3}, d, e);
		transmit_done <= 1'b1;
		@(posedge pclk);
		transmit_done <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			repeat (3) @(posedge pclk);
			#1 check_bit(receiver_active, 1'b0);
			@(posedge pclk);
			bit_clock_en <= 1'b1;
			@(posedge pclk);
			bit_clock_en <= 1'b0;
		end
		repeat (3) @(posedge pclk);
		#1 check_bit(receiver_active, 1'b1);
		ev = taps[1];
		@(posedge pclk);
		#1 check_bit(uart_input, ev);
		apb(1'b1, RECEIVER_SELECT_ADDR, {24'h0, UART_LOW, 6'd5}, d, e);
		transmit_done <= 1'b1;
		@(posedge pclk);
		transmit_done <= 1'b0;
		receive_only_cmd <= 1'b1;
		@(posedge pclk);
		receive_only_cmd <= 1'b0;
		repeat (2) @(posedge pclk);
		#1 check_bit(receiver_active, 1'b1);
		apb(1'b1, RECEIVER_SELECT_ADDR, {24'h0, UART_SIGNAL_INPUT_PIN_MOD, 6'd0}, d, e);
		@(signal_input_pin);
		repeat (4) @(posedge pclk);
		#1 check_bit(uart_input, signal_input_pin);
	endtask : t_guard
	// ==========================================================
	// Sequence and watchdog
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_serial_signal_output_pin();
		t_drivers();
		t_guard();
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		tally_and_finish();
	end
endmodule : tx_serial_signal_output_pin_source_select_tb
